//--- rtl/led_current_ctrl.sv
// single-pin led current controller: edge-count and pwm variants
//
// Summary of operation
// [R1] current code comes from the rising edges counted in one burst
// [R2] burst of edges, then pin held high for latch timeout, then latch
// [R3] after latch timeout the new code drives the sink outputs
// [R4] pin low beyond the off timeout enters shutdown, sinks disabled
// [R5] entering shutdown clears the current code to zero
// [R6] first rising edge out of shutdown wakes and selects code 1
// [R7] each further rising edge advances the code by one step
// [R8] codes 1 to 32 map onto a descending current table per variant
// [R9] one code drives all four sinks together, 32 steps
// [R10] pwm variant: pin activity enables and sets brightness, no counting
// [R11] pwm variant: current linear in duty, full high gives 30 ma
// [R12] pwm variant: pin low over 1 ms shuts the device down
// [R13] doubling mode returns to bypass once input headroom suffices
// [R14] sink open or grounded keeps the device in doubling mode
// [R15] host low pulses last 0.3 to 75 us inside a burst
// [R16] host high phases inside a burst stay under 75 us
// [R17] edges beyond the 32nd hold the code at 32
// [R18] pin synchronised before edge detection; counters fit the timeouts
`default_nettype none
module led_current_ctrl
#(
  parameter led_ctrl_pkg::variant_t VARIANT = led_ctrl_pkg::VAR_HIGH,
  parameter int LAT_CYCLES = led_ctrl_pkg::LAT_CYC,
  parameter int OFF_CYCLES = led_ctrl_pkg::OFF_CYC,
  parameter int PWM_OFF_CYCLES = led_ctrl_pkg::PWM_OFF_CYC,
  parameter int WIN_LOG2 = led_ctrl_pkg::PWM_WIN_LOG2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable_set_line,
  input wire logic headroom_low,
  input wire logic [led_ctrl_pkg::N_SINKS-1:0] sink_untied,
  output var led_ctrl_pkg::sink_drive_t led_sink_outputs_q,
  output var logic [led_ctrl_pkg::CODE_W-1:0] code_q,
  output var logic shutdown_q,
  output var logic doubling_mode_q
);
  import led_ctrl_pkg::*;

  // ****************************************************************
  // elaboration checks and counter sizing
  // ****************************************************************
  localparam int MAX_CYC = (PWM_OFF_CYCLES > OFF_CYCLES) ?
                           PWM_OFF_CYCLES : OFF_CYCLES;
  localparam int TOP_CYC = (MAX_CYC > LAT_CYCLES) ? MAX_CYC : LAT_CYCLES;
  localparam int CNT_W = $clog2(TOP_CYC + 1); // [R18]
  localparam logic [CNT_W-1:0] LAT_LAST = CNT_W'(LAT_CYCLES - 1);
  localparam logic [CNT_W-1:0] OFF_LAST = CNT_W'(OFF_CYCLES - 1);
  localparam logic [CNT_W-1:0] PWM_OFF_LAST = CNT_W'(PWM_OFF_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_TOP = CNT_W'(TOP_CYC);
  localparam bit IS_PWM = (VARIANT == VAR_PWM);

  if (LAT_CYCLES < 2 || OFF_CYCLES < 2 || PWM_OFF_CYCLES < 2) begin : g_chk
    $error("timeout counts must be at least two cycles");
  end
  if (WIN_LOG2 < 4 || WIN_LOG2 > 20) begin : g_chk_win
    $error("pwm window size out of range");
  end

  // ****************************************************************
  // current table lookup
  // ****************************************************************
  function automatic logic [CUR_W-1:0] code_to_dma(
    input logic [CODE_W-1:0] c
  );
    logic [4:0] idx;
    idx = 5'(c - CODE_FIRST);
    if (c == CODE_OFF) begin
      return '0;
    end
    return (VARIANT == VAR_LOW) ? LO_TBL[idx] : HI_TBL[idx]; // [R8]
  endfunction

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  logic pin_s1_q, pin_s2_q, pin_prev_q;
  logic head_s1_q, head_s2_q;
  logic [N_SINKS-1:0] untied_s1_q, untied_s2_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_prev_q <= 1'b0;
    end else begin
      pin_s1_q <= enable_set_line; // [R18]
      pin_s2_q <= pin_s1_q;
      pin_prev_q <= pin_s2_q;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      head_s1_q <= 1'b0;
      head_s2_q <= 1'b0;
      untied_s1_q <= '0;
      untied_s2_q <= '0;
    end else begin
      head_s1_q <= headroom_low;
      head_s2_q <= head_s1_q;
      untied_s1_q <= sink_untied;
      untied_s2_q <= untied_s1_q;
    end
  end

  logic rise;
  assign rise = pin_s2_q && !pin_prev_q; // [R18]

  // ****************************************************************
  // high and low time counters
  // ****************************************************************
  logic [CNT_W-1:0] high_cnt_q, low_cnt_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      high_cnt_q <= '0;
      low_cnt_q <= '0;
    end else begin
      if (!pin_s2_q) begin
        high_cnt_q <= '0;
      end else if (high_cnt_q != CNT_TOP) begin
        high_cnt_q <= high_cnt_q + 1'b1;
      end
      if (pin_s2_q) begin
        low_cnt_q <= '0;
      end else if (low_cnt_q != CNT_TOP) begin
        low_cnt_q <= low_cnt_q + 1'b1;
      end
    end
  end

  logic off_fire, latch_fire;
  assign off_fire = !pin_s2_q &&
                    (low_cnt_q == (IS_PWM ? PWM_OFF_LAST : OFF_LAST));
  assign latch_fire = !IS_PWM && pin_s2_q && (high_cnt_q == LAT_LAST);

  // ****************************************************************
  // power state
  // ****************************************************************
  power_state_t state_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_SHUTDOWN;
    end else begin
      unique case (state_q)
        ST_SHUTDOWN: begin
          if (rise) begin
            state_q <= ST_ACTIVE; // [R6] [R10]
          end
        end
        ST_ACTIVE: begin
          if (off_fire) begin
            state_q <= ST_SHUTDOWN; // [R4] [R12]
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // edge counting and latching (serial variants)
  // ****************************************************************
  logic [CODE_W-1:0] count_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_q <= CODE_OFF;
    end else if (IS_PWM || off_fire) begin
      count_q <= CODE_OFF; // [R5]
    end else if (rise) begin
      if (state_q == ST_SHUTDOWN || count_q == CODE_OFF) begin
        count_q <= CODE_FIRST; // [R6] [R1]
      end else if (count_q != CODE_LAST) begin // [R17]
        count_q <= count_q + 1'b1; // [R7]
      end
    end else if (latch_fire) begin
      count_q <= CODE_OFF;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      code_q <= CODE_OFF;
    end else if (off_fire || IS_PWM) begin
      code_q <= CODE_OFF; // [R5]
    end else if (latch_fire && count_q != CODE_OFF) begin
      code_q <= count_q; // [R2] [R3]
    end
  end

  // ****************************************************************
  // duty measurement (pwm variant)
  // ****************************************************************
  logic [WIN_LOG2-1:0] win_cnt_q;
  logic [WIN_LOG2:0] high_acc_q;
  logic [CUR_W-1:0] pwm_dma_q;
  logic [WIN_LOG2+CUR_W:0] duty_prod;
  logic win_end;

  assign win_end = &win_cnt_q;
  assign duty_prod = (WIN_LOG2+CUR_W+1)'(high_acc_q + pin_s2_q) *
                     PWM_FULL_DMA;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      win_cnt_q <= '0;
      high_acc_q <= '0;
      pwm_dma_q <= '0;
    end else if (!IS_PWM || state_q == ST_SHUTDOWN) begin
      win_cnt_q <= '0;
      high_acc_q <= '0;
      pwm_dma_q <= '0;
    end else if (win_end) begin
      win_cnt_q <= '0;
      high_acc_q <= '0;
      pwm_dma_q <= CUR_W'(duty_prod >> WIN_LOG2); // [R11]
    end else begin
      win_cnt_q <= win_cnt_q + 1'b1;
      high_acc_q <= high_acc_q + pin_s2_q;
    end
  end

  // ****************************************************************
  // sink drive
  // ****************************************************************
  logic [CUR_W-1:0] drive_dma;
  assign drive_dma = IS_PWM ? pwm_dma_q : code_to_dma(code_q); // [R8]

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      led_sink_outputs_q <= '0;
      shutdown_q <= 1'b1;
    end else begin
      shutdown_q <= (state_q == ST_SHUTDOWN);
      led_sink_outputs_q.current_dma <= drive_dma; // [R9]
      led_sink_outputs_q.enable <= {N_SINKS{(state_q == ST_ACTIVE) &&
                                    (drive_dma != '0)}}; // [R9] [R4]
    end
  end

  // ****************************************************************
  // 1x / 2x mode selection
  // ****************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      doubling_mode_q <= 1'b0;
    end else if (state_q == ST_SHUTDOWN) begin
      doubling_mode_q <= 1'b0;
    end else if (head_s2_q || (|untied_s2_q)) begin
      doubling_mode_q <= 1'b1; // [R14]
    end else begin
      doubling_mode_q <= 1'b0; // [R13]
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  sequence s_latch;
    latch_fire && count_q != CODE_OFF && !rise;
  endsequence

  sequence s_wake;
    rise && state_q == ST_SHUTDOWN && !IS_PWM;
  endsequence

  a_latch_apply: assert property (@(posedge clk) disable iff (rst) // [R3]
    s_latch |=> code_q == $past(count_q) ##1
      led_sink_outputs_q.current_dma == code_to_dma($past(code_q)))
    else $error("latched code not applied");

  a_first_edge_one: assert property (@(posedge clk) disable iff (rst) // [R6]
    s_wake |=> count_q == CODE_FIRST && state_q == ST_ACTIVE)
    else $error("wake edge did not select code one");

  a_edge_advance: assert property (@(posedge clk) disable iff (rst) // [R7]
    rise && !IS_PWM && state_q == ST_ACTIVE && !off_fire &&
    count_q != CODE_OFF && count_q != CODE_LAST
    |=> count_q == $past(count_q) + 1'b1)
    else $error("edge did not advance code");

  a_code_saturate: assert property (@(posedge clk) disable iff (rst) // [R17]
    count_q <= CODE_LAST && code_q <= CODE_LAST)
    else $error("code beyond last step");

  a_off_entry: assert property (@(posedge clk) disable iff (rst) // [R4]
    off_fire && state_q == ST_ACTIVE |=> state_q == ST_SHUTDOWN ##1
      (shutdown_q && led_sink_outputs_q.enable == '0))
    else $error("off timeout did not shut down");

  a_shutdown_clear: assert property (@(posedge clk) disable iff (rst) // [R5]
    $rose(shutdown_q) |-> code_q == CODE_OFF && $past(count_q) == CODE_OFF)
    else $error("code not cleared in shutdown");

  a_sinks_together: assert property (@(posedge clk) disable iff (rst) // [R9]
    led_sink_outputs_q.enable == '0 || (&led_sink_outputs_q.enable))
    else $error("sinks enabled apart");

  a_pwm_full: assert property (@(posedge clk) disable iff (rst) // [R11]
    IS_PWM && win_end && state_q == ST_ACTIVE &&
    high_acc_q == (WIN_LOG2+1)'(1 << WIN_LOG2) - 1'b1 && pin_s2_q
    |=> pwm_dma_q == PWM_FULL_DMA)
    else $error("full duty not full current");

  a_pwm_low_off: assert property (@(posedge clk) disable iff (rst) // [R12]
    IS_PWM && !pin_s2_q && low_cnt_q == PWM_OFF_LAST &&
    state_q == ST_ACTIVE |=> state_q == ST_SHUTDOWN)
    else $error("pwm low did not shut down");

  a_double_forced: assert property (@(posedge clk) disable iff (rst) // [R14]
    state_q == ST_ACTIVE && (|untied_s2_q) |=> doubling_mode_q)
    else $error("untied sink left doubling mode");

  a_double_exit: assert property (@(posedge clk) disable iff (rst) // [R13]
    doubling_mode_q && !head_s2_q && untied_s2_q == '0 |=> !doubling_mode_q)
    else $error("doubling mode not released");
endmodule
`default_nettype wire

//--- rtl/led_ctrl_pkg.sv
// constants, tables and carrier types of the led current controller
`default_nettype none
package led_ctrl_pkg;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_PS = 5000;
  localparam int LAT_TIME_US = 500;
  localparam int OFF_TIME_US = 500;
  localparam int PWM_OFF_TIME_US = 1000;
  // longest times, rounded down
  localparam int LAT_CYC = (LAT_TIME_US * 1000000) / CLK_PERIOD_PS;
  localparam int OFF_CYC = (OFF_TIME_US * 1000000) / CLK_PERIOD_PS;
  localparam int PWM_OFF_CYC = (PWM_OFF_TIME_US * 1000000) / CLK_PERIOD_PS;
  // duty window is 2**PWM_WIN_LOG2 cycles
  localparam int PWM_WIN_LOG2 = 14;

  // ****************************************************************
  // codes and currents (units of 0.1 ma)
  // ****************************************************************
  localparam int CODE_W = 6;
  localparam int CUR_W = 9;
  localparam int N_SINKS = 4;
  localparam logic [CODE_W-1:0] CODE_OFF = 6'h00;
  localparam logic [CODE_W-1:0] CODE_FIRST = 6'h01;
  localparam logic [CODE_W-1:0] CODE_LAST = 6'h20;
  localparam logic [CUR_W-1:0] PWM_FULL_DMA = 9'h12c;
  localparam logic [CUR_W-1:0] HI_TBL [32] = '{
    9'h12c, 9'h122, 9'h119, 9'h10f, 9'h105, 9'h0fb, 9'h0f2, 9'h0e8,
    9'h0df, 9'h0d5, 9'h0cb, 9'h0c2, 9'h0b8, 9'h0ae, 9'h0a5, 9'h09b,
    9'h091, 9'h088, 9'h07e, 9'h074, 9'h06b, 9'h061, 9'h057, 9'h04d,
    9'h044, 9'h03a, 9'h030, 9'h027, 9'h01d, 9'h013, 9'h00a, 9'h005};
  localparam logic [CUR_W-1:0] LO_TBL [32] = '{
    9'h0cd, 9'h0c6, 9'h0c0, 9'h0b9, 9'h0b2, 9'h0ac, 9'h0a5, 9'h09e,
    9'h098, 9'h091, 9'h08b, 9'h084, 9'h07d, 9'h077, 9'h070, 9'h06a,
    9'h063, 9'h05c, 9'h056, 9'h04f, 9'h049, 9'h042, 9'h03b, 9'h035,
    9'h02e, 9'h028, 9'h021, 9'h01a, 9'h014, 9'h00d, 9'h007, 9'h003};

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {VAR_HIGH, VAR_LOW, VAR_PWM} variant_t;
  typedef enum logic {ST_SHUTDOWN, ST_ACTIVE} power_state_t;
  typedef struct packed {
    logic [N_SINKS-1:0] enable;
    logic [CUR_W-1:0] current_dma;
  } sink_drive_t;
endpackage
`default_nettype wire

//--- tb/pin_host_model.sv
// host model driving the single control pin of the led controller
`default_nettype none
module pin_host_model #(
  parameter int LOW_CYC = 3,
  parameter int HIGH_CYC = 3
) (
  input wire logic clk,
  output var logic pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // pin drive tasks, entered just after a rising edge
  // ****************************************************************
  initial begin
    pin = 1'b0;
  end
  // hold a level for a number of clocks
  task automatic hold(input logic v, input int cyc);
    pin <= v;
    repeat (cyc) @(posedge clk);
  endtask
  // burst of n rising edges, ending high
  task automatic pulses(input int n);
    for (int i = 0; i < n; i++) begin
      hold(1'b0, LOW_CYC);
      hold(1'b1, HIGH_CYC);
    end
  endtask
  // square wave with hi clocks high out of per
  task automatic pwm(input int hi, input int per, input int reps);
    for (int i = 0; i < reps; i++) begin
      hold(1'b1, hi);
      hold(1'b0, per - hi);
    end
  endtask
endmodule
`default_nettype wire

//--- tb/test_edge_count_led_current_control.sv
// self-checking bench of the led current controller
`default_nettype none
module test_edge_count_led_current_control;
  timeunit 1ns;
  timeprecision 1ps;
  import led_ctrl_pkg::*;
  // ****************************************************************
  // set-up
  // ****************************************************************
  localparam int LAT = 50;
  localparam int OFF = 50;
  localparam int POFF = 100;
  localparam int WLOG = 6;
  logic clk;
  logic rst;
  logic ser_pin;
  logic pwm_pin;
  logic headroom_low;
  logic [N_SINKS-1:0] sink_untied;
  sink_drive_t out_hi;
  sink_drive_t out_lo;
  sink_drive_t out_pwm;
  logic [CODE_W-1:0] code_hi;
  logic [CODE_W-1:0] code_pwm;
  logic shdn_hi;
  logic shdn_pwm;
  logic dbl_hi;
  int num_errors = 0;
  int compares = 0;

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  pin_host_model host (.clk(clk), .pin(ser_pin));
  pin_host_model pwm_host (.clk(clk), .pin(pwm_pin));

  led_current_ctrl #(.VARIANT(VAR_HIGH), .LAT_CYCLES(LAT),
    .OFF_CYCLES(OFF), .PWM_OFF_CYCLES(POFF), .WIN_LOG2(WLOG)) dut (
    .clk(clk), .rst(rst), .enable_set_line(ser_pin),
    .headroom_low(headroom_low), .sink_untied(sink_untied),
    .led_sink_outputs_q(out_hi), .code_q(code_hi), .shutdown_q(shdn_hi),
    .doubling_mode_q(dbl_hi));
  led_current_ctrl #(.VARIANT(VAR_LOW), .LAT_CYCLES(LAT),
    .OFF_CYCLES(OFF), .PWM_OFF_CYCLES(POFF), .WIN_LOG2(WLOG)) dut_lo (
    .clk(clk), .rst(rst), .enable_set_line(ser_pin),
    .headroom_low(headroom_low), .sink_untied(sink_untied),
    .led_sink_outputs_q(out_lo), .code_q(), .shutdown_q(),
    .doubling_mode_q());
  led_current_ctrl #(.VARIANT(VAR_PWM), .LAT_CYCLES(LAT),
    .OFF_CYCLES(OFF), .PWM_OFF_CYCLES(POFF), .WIN_LOG2(WLOG)) dut_pwm (
    .clk(clk), .rst(rst), .enable_set_line(pwm_pin),
    .headroom_low(headroom_low), .sink_untied(sink_untied),
    .led_sink_outputs_q(out_pwm), .code_q(code_pwm),
    .shutdown_q(shdn_pwm), .doubling_mode_q());

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic check_ser(input logic [5:0] c, input logic [8:0] ih,
                           input logic [8:0] il);
    check("code", 16'(c), 16'(code_hi));
    check("current high", 16'(ih), 16'(out_hi.current_dma));
    check("current low", 16'(il), 16'(out_lo.current_dma));
    check("enable", 16'h000f, 16'(out_hi.enable));
  endtask

  task automatic burst_latch(input int n);
    host.pulses(n);
    host.hold(1'b1, LAT + 8);
  endtask

  task automatic complete_run();
    if (num_errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    check("shutdown", 16'h1, 16'(shdn_hi));
    check("code", 16'h0, 16'(code_hi));
    check("outputs", 16'h0, 16'(out_hi));
  endtask

  task automatic t_wake();
    host.pulses(1);
    host.hold(1'b1, LAT - 10);
    check("shutdown", 16'h0, 16'(shdn_hi));
    check("code early", 16'h0, 16'(code_hi));
    host.hold(1'b1, 18);
    check_ser(6'h01, 9'h12c, 9'h0cd);
  endtask

  task automatic t_codes();
    int n[3] = '{2, 16, 31};
    foreach (n[i]) begin
      burst_latch(n[i]);
      check_ser(6'(n[i]), HI_TBL[n[i]-1], LO_TBL[n[i]-1]);
    end
    burst_latch(35);
    check_ser(6'h20, 9'h005, 9'h003);
  endtask

  task automatic t_off();
    host.hold(1'b0, OFF - 10);
    host.hold(1'b1, LAT + 8);
    check("shutdown", 16'h0, 16'(shdn_hi));
    check_ser(6'h01, 9'h12c, 9'h0cd);
    host.hold(1'b0, OFF + 6);
    check("shutdown", 16'h1, 16'(shdn_hi));
    check("code", 16'h0, 16'(code_hi));
    check("enable", 16'h0, 16'(out_hi.enable));
    burst_latch(3);
    check_ser(6'h03, HI_TBL[2], LO_TBL[2]);
  endtask

  task automatic t_double();
    headroom_low <= 1'b1;
    repeat (6) @(posedge clk);
    check("doubling", 16'h1, 16'(dbl_hi));
    headroom_low <= 1'b0;
    repeat (6) @(posedge clk);
    check("doubling", 16'h0, 16'(dbl_hi));
    sink_untied <= 4'h4;
    repeat (6) @(posedge clk);
    check("doubling", 16'h1, 16'(dbl_hi));
    sink_untied <= 4'h0;
    repeat (6) @(posedge clk);
    check("doubling", 16'h0, 16'(dbl_hi));
  endtask

  task automatic t_pwm();
    pwm_host.hold(1'b1, 4 << WLOG);
    check("pwm full", 16'h012c, 16'(out_pwm.current_dma));
    check("pwm code", 16'h0, 16'(code_pwm));
    check("pwm enable", 16'h000f, 16'(out_pwm.enable));
    pwm_host.pwm(4, 8, 4 << (WLOG - 3));
    check("pwm half", 16'h0096, 16'(out_pwm.current_dma));
    pwm_host.pwm(2, 8, 4 << (WLOG - 3));
    check("pwm quarter", 16'h004b, 16'(out_pwm.current_dma));
    pwm_host.hold(1'b0, POFF + 10);
    check("pwm shutdown", 16'h1, 16'(shdn_pwm));
  endtask

  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial begin
    rst = 1'b1;
    headroom_low = 1'b0;
    sink_untied = 4'h0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_wake();
    t_codes();
    t_off();
    t_double();
    t_pwm();
    complete_run();
  end

  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    complete_run();
  end
endmodule
`default_nettype wire
